// *** common/psa_pkg.sv ***
/*
  constants shared by the program space access unit and its core-side requester.
  assumes a 24-bit instruction word and a 16-bit data word.
*/
package psa_pkg;
  localparam int PC_W = 23;
  localparam int PADDR_W = 24;
  localparam int IWORD_W = 24;
  localparam int DWORD_W = 16;
  localparam int DADDR_W = 16;
  localparam int PAGE_W = 8;
  localparam int CFG_SEL_BIT = 7;
  localparam int LATCH_WORDS = 32;
  localparam int LATCH_IDX_W = 5;
  localparam logic [PADDR_W-1:0] USER_TOP = 24'h7ffffe;
  localparam logic [PADDR_W-1:0] PC_STEP = 24'h000002;
  localparam logic [DADDR_W-1:0] WINDOW_BASE = 16'h8000;
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // flash control write-start bit position
  localparam int WR_BIT = 15;
  // requester register offsets (byte addresses on avalon)
  localparam logic [3:0] REG_CMD = 4'h0;
  localparam logic [3:0] REG_ADDR = 4'h4;
  localparam logic [3:0] REG_WDATA = 4'h8;
  localparam logic [3:0] REG_RDATA = 4'hc;
  // command encodings
  localparam logic [2:0] OP_NONE = 3'h0;
  localparam logic [2:0] OP_DATA_RD = 3'h1;
  localparam logic [2:0] OP_TBL_RD = 3'h2;
  localparam logic [2:0] OP_TBL_WL = 3'h3;
  localparam logic [2:0] OP_TBL_WH = 3'h4;
  localparam logic [2:0] OP_SET_PAGE = 3'h5;
  localparam logic [2:0] OP_KEY = 3'h6;
  localparam logic [2:0] OP_CTRL = 3'h7;
  // pages selected by the page field of op_set_page
  localparam logic [1:0] PG_WINDOW = 2'h0;
  localparam logic [1:0] PG_TABLE = 2'h1;
  localparam int PROG_CYCLES = 64;
endpackage

// *** common/psa_if.sv ***
/*
  link between the core-side requester and the program space access unit.
  assumes both ends share clk and rst.
*/
`timescale 1ns/1ps
interface psa_if;
  logic req;
  logic [2:0] op;
  logic [15:0] addr;
  logic [15:0] wdata;
  logic ack;
  logic [15:0] rdata;
  logic [7:0] rdata_hi;
  logic busy;
  modport unit (input req, op, addr, wdata, output ack, rdata, rdata_hi, busy);
  modport core (output req, op, addr, wdata, input ack, rdata, rdata_hi, busy);
endinterface

// *** rtl/program_space_access_unit.sv ***
/*
  program space access unit: window and table access to program memory,
  flash write latches and the keyed unlock that starts programming.
  assumes the core holds req with op, addr and wdata until ack.
  the flash array is a plain port pair; the array answers in one cycle.
*/
`timescale 1ns/1ps
// Behaviour
// - 23-bit pc, lsb always zero
// - program address steps by two
// - upper data half maps via page register
// - window access extra cycle, low 16 bits
// - table access reaches all 24 bits
// - user space only, except table page bit7
// - address bit 23 only for table access
// - 96 bytes of write latches, 32 words
// - high-byte write keeps low byte only
// - no erase/program without unlock sequence
// - software writes 0x55, 0xaa, then start
// - software idles two slots, then waits
// - software holds off interrupts five instructions
module program_space_access_unit #(
  parameter int PROG_CYCLES = psa_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  psa_if.unit link,
  input wire logic [psa_pkg::PC_W-1:0] pc_in,
  input wire logic pc_load,
  input wire logic pc_advance,
  output logic [psa_pkg::PC_W-1:0] pc,
  output logic [psa_pkg::PADDR_W-1:0] flash_addr,
  output logic flash_rd,
  input wire logic [psa_pkg::IWORD_W-1:0] flash_rdata,
  output logic flash_prog,
  output logic [psa_pkg::IWORD_W*psa_pkg::LATCH_WORDS-1:0] flash_latch_data,
  output logic [psa_pkg::PADDR_W-1:0] flash_prog_addr,
  output logic [15:0] flash_control,
  output logic unlocked
);
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_DONE} acc_state_t;
  typedef enum logic [1:0] {K_NONE, K_ONE, K_TWO} key_state_t;
  acc_state_t state_reg;
  key_state_t key_reg;
  logic [psa_pkg::PC_W-1:0] pc_reg;
  logic [psa_pkg::PAGE_W-1:0] data_window_page;
  logic [psa_pkg::PAGE_W-1:0] table_page_select;
  logic [psa_pkg::IWORD_W-1:0] latch_mem [psa_pkg::LATCH_WORDS];
  logic [15:0] rdata_reg;
  logic [7:0] rdata_hi_reg;
  logic [15:0] ctrl_reg;
  logic [psa_pkg::PADDR_W-1:0] prog_addr_reg;
  logic [$clog2(PROG_CYCLES+1)-1:0] prog_cnt_reg;
  logic [psa_pkg::PADDR_W-1:0] win_addr;
  logic [psa_pkg::PADDR_W-1:0] tbl_addr;
  logic [psa_pkg::LATCH_IDX_W-1:0] latch_idx;
  logic take;
  logic is_write;
  logic start_ok;
  logic flash_rd_window;

  assign take = link.req && (state_reg == ST_IDLE);
  assign is_write = link.op != psa_pkg::OP_DATA_RD && link.op != psa_pkg::OP_TBL_RD
    && link.op != psa_pkg::OP_NONE;
  // window address: page picks a 16k-word slice, bit 23 clear, word aligned
  assign win_addr = {1'b0, data_window_page, link.addr[14:1], 1'b0};
  // table address: page bit 7 becomes address bit 23 only here
  assign tbl_addr = {table_page_select, link.addr};
  // latch slot from word address; two address units per word
  assign latch_idx = link.addr[psa_pkg::LATCH_IDX_W:1];
  assign start_ok = (key_reg == K_TWO) && link.wdata[psa_pkg::WR_BIT];

  // program counter, lsb forced clear
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pc_reg <= '0;
    end else if (pc_load) begin
      pc_reg <= {pc_in[psa_pkg::PC_W-1:1], 1'b0};
    end else if (pc_advance) begin
      pc_reg <= pc_reg + psa_pkg::PC_STEP[psa_pkg::PC_W-1:0];
    end
  end
  assign pc = pc_reg;

  // access sequencer: reads wait one cycle for the array
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= ST_IDLE;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          if (take && (link.op == psa_pkg::OP_DATA_RD || link.op == psa_pkg::OP_TBL_RD)) begin
            state_reg <= ST_WAIT;
          end else if (take) begin
            state_reg <= ST_DONE;
          end
        end
        ST_WAIT: state_reg <= ST_DONE;
        ST_DONE: state_reg <= ST_IDLE;
      endcase
    end
  end
  assign link.ack = state_reg == ST_DONE;

  // flash read port, address held while waiting
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_addr <= '0;
      flash_rd <= 1'b0;
    end else begin
      flash_rd <= take && (link.op == psa_pkg::OP_DATA_RD || link.op == psa_pkg::OP_TBL_RD);
      if (take && link.op == psa_pkg::OP_DATA_RD) begin
        flash_addr <= win_addr;
      end else if (take && link.op == psa_pkg::OP_TBL_RD) begin
        flash_addr <= tbl_addr;
      end
    end
  end

  // read data capture: window gives low word only, table gives all 24 bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
      rdata_hi_reg <= '0;
    end else if (state_reg == ST_WAIT) begin
      rdata_reg <= flash_rdata[15:0];
      rdata_hi_reg <= flash_rd_window ? 8'h00 : flash_rdata[23:16];
    end
  end
  // remembers whether the pending read came through the data window
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      flash_rd_window <= 1'b0;
    end else if (take) begin
      flash_rd_window <= link.op == psa_pkg::OP_DATA_RD;
    end
  end
  assign link.rdata = rdata_reg;
  assign link.rdata_hi = rdata_hi_reg;

  // page registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      data_window_page <= '0;
      table_page_select <= '0;
    end else if (take && link.op == psa_pkg::OP_SET_PAGE) begin
      if (link.addr[1:0] == psa_pkg::PG_WINDOW) begin
        data_window_page <= link.wdata[7:0];
      end else if (link.addr[1:0] == psa_pkg::PG_TABLE) begin
        table_page_select <= link.wdata[7:0];
      end
    end
  end

  // write latches, one 24-bit word per slot
  always_ff @(posedge clk) begin
    if (take && link.op == psa_pkg::OP_TBL_WL) begin
      latch_mem[latch_idx][15:0] <= link.wdata;
    end else if (take && link.op == psa_pkg::OP_TBL_WH) begin
      latch_mem[latch_idx][23:16] <= link.wdata[7:0]; // upper source byte dropped
    end
  end
  for (genvar i = 0; i < psa_pkg::LATCH_WORDS; i++) begin : g_latch
    assign flash_latch_data[i*psa_pkg::IWORD_W +: psa_pkg::IWORD_W] = latch_mem[i];
  end

  // remember latch row address for programming
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      prog_addr_reg <= '0;
    end else if (take && link.op == psa_pkg::OP_TBL_WL) begin
      prog_addr_reg <= {tbl_addr[23:psa_pkg::LATCH_IDX_W+1], 6'h00};
    end
  end
  assign flash_prog_addr = prog_addr_reg;

  // unlock key sequence; any other write in between cancels it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_reg <= K_NONE;
    end else if (take && is_write) begin
      if (link.op == psa_pkg::OP_KEY && link.wdata[7:0] == psa_pkg::KEY_FIRST) begin
        key_reg <= K_ONE;
      end else if (link.op == psa_pkg::OP_KEY && link.wdata[7:0] == psa_pkg::KEY_SECOND
                   && key_reg == K_ONE) begin
        key_reg <= K_TWO;
      end else begin
        key_reg <= K_NONE;
      end
    end
  end
  assign unlocked = key_reg == K_TWO;

  // flash control: write-start only honoured after unlock, cleared on finish
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ctrl_reg <= '0;
      prog_cnt_reg <= '0;
    end else if (ctrl_reg[psa_pkg::WR_BIT]) begin
      if (prog_cnt_reg == '0) begin
        ctrl_reg[psa_pkg::WR_BIT] <= 1'b0;
      end else begin
        prog_cnt_reg <= prog_cnt_reg - 1'b1;
      end
    end else if (take && link.op == psa_pkg::OP_CTRL) begin
      ctrl_reg <= {start_ok, link.wdata[14:0]};
      prog_cnt_reg <= ($clog2(PROG_CYCLES+1))'(PROG_CYCLES - 1);
    end
  end
  assign flash_control = ctrl_reg;
  assign flash_prog = ctrl_reg[psa_pkg::WR_BIT];
  // software idles and waits on busy; hardware needs nothing from it
  assign link.busy = ctrl_reg[psa_pkg::WR_BIT];
endmodule

// *** rtl/psa_core_requester.sv ***
/*
  core-side requester: takes orders from software over avalon-mm and
  issues them on the link. assumes software follows the unlock order itself.
*/
`timescale 1ns/1ps
module psa_core_requester (
  input wire logic clk,
  input wire logic rst,
  psa_if.core link,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest
);
  typedef enum logic [1:0] {S_IDLE, S_BUSY, S_RESP} req_state_t;
  req_state_t state_reg;
  logic [2:0] op_reg;
  logic [15:0] addr_reg;
  logic [15:0] wdata_reg;
  logic [23:0] rdata_reg;
  logic [31:0] readdata_reg;
  logic launch;

  assign launch = state_reg == S_IDLE && avs_write && avs_address == psa_pkg::REG_CMD
    && avs_writedata[2:0] != psa_pkg::OP_NONE;

  // link sequencer; the avalon write to cmd stalls until the unit acks
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= S_IDLE;
      op_reg <= psa_pkg::OP_NONE;
    end else begin
      unique case (state_reg)
        S_IDLE: if (launch) begin
          state_reg <= S_BUSY;
          op_reg <= avs_writedata[2:0];
        end
        S_BUSY: if (link.ack) begin
          state_reg <= S_RESP;
        end
        S_RESP: state_reg <= S_IDLE;
      endcase
    end
  end
  assign link.req = state_reg == S_BUSY;
  assign link.op = op_reg;
  assign link.addr = addr_reg;
  assign link.wdata = wdata_reg;

  // operand registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
      wdata_reg <= '0;
    end else if (state_reg == S_IDLE && avs_write) begin
      if (avs_address == psa_pkg::REG_ADDR) begin
        addr_reg <= avs_writedata[15:0];
      end else if (avs_address == psa_pkg::REG_WDATA) begin
        wdata_reg <= avs_writedata[15:0];
      end
    end
  end

  // capture read result, all 24 bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_reg <= '0;
    end else if (state_reg == S_BUSY && link.ack) begin
      rdata_reg <= {link.rdata_hi, link.rdata};
    end
  end

  // register read, one cycle of wait then data; unmapped reads zero
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readdata_reg <= '0;
    end else begin
      unique case (avs_address)
        psa_pkg::REG_CMD: readdata_reg <= {28'h0000000, link.busy, op_reg};
        psa_pkg::REG_ADDR: readdata_reg <= {16'h0000, addr_reg};
        psa_pkg::REG_WDATA: readdata_reg <= {16'h0000, wdata_reg};
        psa_pkg::REG_RDATA: readdata_reg <= {8'h00, rdata_reg};
        default: readdata_reg <= '0;
      endcase
    end
  end
  logic rd_ready_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      rd_ready_reg <= 1'b0;
    end else begin
      rd_ready_reg <= avs_read && !rd_ready_reg;
    end
  end
  assign avs_readdata = readdata_reg;
  assign avs_waitrequest = avs_read ? !rd_ready_reg
    : (avs_write && avs_address == psa_pkg::REG_CMD && state_reg != S_RESP
       && (state_reg != S_IDLE || launch));
endmodule

// *** dv/program_space_access_unit_assertions.sv ***
/*
  link checker for the program space access unit and its requester.
  assumes it sees the psa_if signals of the bench as plain inputs.
*/
`timescale 1ns/1ps
module program_space_access_unit_assertions #(
  parameter int PROG_CYCLES = psa_pkg::PROG_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic req,
  input wire logic [2:0] op,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic ack,
  input wire logic [15:0] rdata,
  input wire logic [7:0] rdata_hi,
  input wire logic busy
);
  logic [1:0] key_reg;
  logic [7:0] busy_cnt_reg;
  logic rd_op;
  logic start_req;
  assign rd_op = op == psa_pkg::OP_DATA_RD || op == psa_pkg::OP_TBL_RD;
  // busy as it was at the take: an accepted start is already busy when ack shows
  assign start_req = ack && op == psa_pkg::OP_CTRL && wdata[psa_pkg::WR_BIT]
    && busy_cnt_reg == 8'h0;
  // unlock progress seen on the link; reads leave it, any other write cancels it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      key_reg <= 2'h0;
    end else if (ack) begin
      key_reg <= (op == psa_pkg::OP_KEY && wdata[7:0] == psa_pkg::KEY_FIRST) ? 2'h1 :
        (op == psa_pkg::OP_KEY && wdata[7:0] == psa_pkg::KEY_SECOND && key_reg == 2'h1) ? 2'h2 :
        rd_op ? key_reg : 2'h0;
    end
  end
  // length of the programming pulse, so its time can be judged when it ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      busy_cnt_reg <= 8'h0;
    end else begin
      busy_cnt_reg <= busy ? busy_cnt_reg + 8'h1 : 8'h0;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_take_read;
    $rose(req) && rd_op;
  endsequence
  property p_read_slow; s_take_read |-> !ack[*2] ##[0:2] ack; endproperty
  a_read_slow: assert property (p_read_slow) else $error("read answered too soon or late");
  property p_write_answer; $rose(req) && !rd_op |-> ##[1:3] ack; endproperty
  a_write_answer: assert property (p_write_answer) else $error("write not answered");
  property p_ack_pulse; ack |=> !ack && !req; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack or req held too long");
  property p_req_hold; req && !ack |=> req && $stable(op) && $stable(addr) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold) else $error("request changed before ack");
  property p_rdata_cause; $changed(rdata) || $changed(rdata_hi) |-> req && rd_op; endproperty
  a_rdata_cause: assert property (p_rdata_cause) else $error("read data moved unread");
  property p_start_refused; start_req && key_reg != 2'h2 |=> !busy[*3]; endproperty
  a_start_refused: assert property (p_start_refused) else $error("start without unlock");
  property p_start_taken; start_req && key_reg == 2'h2 |-> ##[0:2] busy; endproperty
  a_start_taken: assert property (p_start_taken) else $error("unlocked start ignored");
  property p_busy_cause; $rose(busy) |-> $past(key_reg) == 2'h2 || $past(key_reg, 2) == 2'h2;
  endproperty
  a_busy_cause: assert property (p_busy_cause) else $error("busy rose without keys");
  property p_prog_time;
    $fell(busy) |-> $past(busy_cnt_reg) >= PROG_CYCLES - 1
      && $past(busy_cnt_reg) <= PROG_CYCLES + 1;
  endproperty
  a_prog_time: assert property (p_prog_time) else $error("start bit cleared at wrong time");
endmodule

// *** dv/program_space_access_unit_bench.sv ***
/*
  bench: software orders over avalon to the requester, which drives the unit.
  assumes a combinational flash array model and a short programming time.
*/
`timescale 1ns/1ps
module program_space_access_unit_bench;
  localparam int PROG_N = 4;
  typedef struct {
    logic [2:0] op;
    logic [15:0] a;
    logic [15:0] d;
    logic [1:0] k;
    logic [23:0] ea;
  } row_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, rd;
  logic avs_waitrequest, flash_rd, flash_prog, unlocked;
  logic pc_load = 1'b0;
  logic pc_advance = 1'b0;
  logic [22:0] pc_in = 23'h0;
  logic [22:0] pc;
  logic [23:0] flash_addr, flash_rdata, flash_prog_addr, ex;
  logic [767:0] flash_latch_data;
  logic [15:0] flash_control;
  int mismatches = 0, checks = 0, cyc = 0, pcnt = 0, n;
  row_t rows[10];
  psa_if link();
  program_space_access_unit #(.PROG_CYCLES(PROG_N)) program_space_access_unit_inst (.clk(clk),
    .rst(rst), .link(link), .pc_in(pc_in), .pc_load(pc_load), .pc_advance(pc_advance), .pc(pc),
    .flash_addr(flash_addr), .flash_rd(flash_rd), .flash_rdata(flash_rdata),
    .flash_prog(flash_prog), .flash_latch_data(flash_latch_data), .flash_prog_addr(flash_prog_addr),
    .flash_control(flash_control), .unlocked(unlocked));
  psa_core_requester psa_core_requester_inst (.clk(clk), .rst(rst), .link(link),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  program_space_access_unit_assertions #(.PROG_CYCLES(PROG_N))
    program_space_access_unit_assertions_inst (.clk(clk), .rst(rst), .req(link.req), .op(link.op),
    .addr(link.addr), .wdata(link.wdata), .ack(link.ack), .rdata(link.rdata),
    .rdata_hi(link.rdata_hi), .busy(link.busy));
  // flash array: scrambled so every address bit shows in the word
  function automatic logic [23:0] fm(input logic [23:0] a);
    return a ^ 24'ha55a5a;
  endfunction
  assign flash_rdata = fm(flash_addr);
  always #10 clk = ~clk;
  // cut a hang short; also count programming pulse length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (flash_prog === 1'b1) pcnt <= pcnt + 1;
    if (cyc == 20000) begin
      mismatches++;
      complete_run();
    end
  end
  task check(input string what, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", what, e, s);
    end
  endtask
  // one avalon transfer, held until the rising edge that sees waitrequest low
  task av(input logic wr, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0) @(posedge clk);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask
  task cmd(input logic [2:0] op, input logic [15:0] a, input logic [15:0] d);
    av(1'b1, psa_pkg::REG_ADDR, {16'h0, a});
    av(1'b1, psa_pkg::REG_WDATA, {16'h0, d});
    av(1'b1, psa_pkg::REG_CMD, {29'h0, op});
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    // kind 1 window read, 2 table read, 3 latch slot
    rows = '{'{psa_pkg::OP_SET_PAGE, 16'h0, 16'h12, 2'h0, 24'h0},
      '{psa_pkg::OP_DATA_RD, 16'h8006, 16'h0, 2'h1, 24'h090006},
      '{psa_pkg::OP_SET_PAGE, 16'h1, 16'h80, 2'h0, 24'h0},
      '{psa_pkg::OP_TBL_RD, 16'h1234, 16'h0, 2'h2, 24'h801234},
      '{psa_pkg::OP_SET_PAGE, 16'h1, 16'h0, 2'h0, 24'h0},
      '{psa_pkg::OP_TBL_RD, 16'hfffe, 16'h0, 2'h2, 24'h00fffe},
      '{psa_pkg::OP_TBL_WL, 16'h2, 16'hbeef, 2'h0, 24'h0},
      '{psa_pkg::OP_TBL_WH, 16'h2, 16'hff3c, 2'h3, 24'h3cbeef},
      '{psa_pkg::OP_TBL_WL, 16'h3e, 16'h1234, 2'h0, 24'h0},
      '{psa_pkg::OP_TBL_WH, 16'h3e, 16'h0056, 2'h3, 24'h561234}};
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    foreach (rows[i]) begin
      cmd(rows[i].op, rows[i].a, rows[i].d);
      av(1'b0, psa_pkg::REG_RDATA, 32'h0);
      ex = fm(rows[i].ea);
      n = rows[i].a[5:1];
      // window reads must show no upper byte at all
      if (rows[i].k == 2'h1) check("window data", {16'h0, ex[15:0]}, rd);
      if (rows[i].k inside {2'h1, 2'h2}) check("flash addr", rows[i].ea, flash_addr);
      if (rows[i].k == 2'h2) check("table word", ex, rd);
      if (rows[i].k == 2'h3) check("latch", rows[i].ea, flash_latch_data[n*24 +: 24]);
    end
    // odd load is forced even, then two steps wrap the 23-bit counter
    pc_in <= 23'h7ffffd;
    pc_load <= 1'b1;
    @(posedge clk);
    pc_load <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      @(negedge clk);
      check("pc", 23'(23'h7ffffc + 2 * k), pc);
      @(posedge clk);
      pc_advance <= 1'b1;
      @(posedge clk);
      pc_advance <= 1'b0;
    end
    // a write between the keys cancels the unlock
    cmd(psa_pkg::OP_KEY, 16'h0, 16'h55);
    cmd(psa_pkg::OP_TBL_WL, 16'h0044, 16'h0);
    check("prog row", 24'h000040, flash_prog_addr);
    cmd(psa_pkg::OP_KEY, 16'h0, 16'haa);
    check("cancelled unlock", 0, unlocked);
    cmd(psa_pkg::OP_CTRL, 16'h0, 16'h8000);
    check("refused start", 0, flash_control[15]);
    // keys back to back, no write may slip in between them
    cmd(psa_pkg::OP_KEY, 16'h0, 16'h55);
    cmd(psa_pkg::OP_KEY, 16'h0, 16'haa);
    check("unlocked", 1, unlocked);
    cmd(psa_pkg::OP_CTRL, 16'h0, 16'h8000);
    // software issues nothing to the unit; it reads the busy status once, then the bench waits on flash_prog
    av(1'b0, psa_pkg::REG_CMD, 32'h0);
    check("busy status", {28'h0, 1'b1, psa_pkg::OP_CTRL}, rd);
    n = 0;
    while (flash_prog !== 1'b0 && n < 50) begin
      @(posedge clk);
      n++;
    end
    check("program time", 1, pcnt inside {[PROG_N:PROG_N + 1]});
    check("start cleared", 0, flash_control[15]);
    av(1'b0, 4'h2, 32'h0);
    check("unmapped read", 0, rd);
    // reset in mid-run while unlocked
    cmd(psa_pkg::OP_KEY, 16'h0, 16'h55);
    cmd(psa_pkg::OP_KEY, 16'h0, 16'haa);
    rst <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    check("reset pc", 0, pc);
    check("reset state", 0, {unlocked, flash_control});
    @(posedge clk);
    rst <= 1'b0;
    // the completed unlock is gone: a lone second key must not unlock
    cmd(psa_pkg::OP_KEY, 16'h0, 16'haa);
    check("key after reset", 0, unlocked);
    complete_run();
  end
endmodule
